// ### sfwp_pkg.sv
// Constants, opcodes, field positions and types of the serial flash write-protect block.
// Assumes a single SPI host; the array datapath sits outside this block.
package sfwp_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int OP_TIME_NS = 2000;
	localparam int OP_CYCLES_INT = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [15:0] OP_CYCLES = 16'(OP_CYCLES_INT);

	// ************************************************************
	// Command opcodes
	// ************************************************************
	localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;
	localparam logic [7:0] OPC_PAGE_PROG = 8'h02;
	localparam logic [7:0] OPC_WRITE_LOCK = 8'h04;
	localparam logic [7:0] OPC_READ_STATUS_LO = 8'h05;
	localparam logic [7:0] OPC_WRITE_UNLOCK = 8'h06;
	localparam logic [7:0] OPC_READ_CONFIG = 8'h15;
	localparam logic [7:0] OPC_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] OPC_RESUME_B = 8'h30;
	localparam logic [7:0] OPC_WRITE_CONFIG = 8'h31;
	localparam logic [7:0] OPC_QUAD_PROG = 8'h32;
	localparam logic [7:0] OPC_READ_STATUS_HI = 8'h35;
	localparam logic [7:0] OPC_BLOCK32_ERASE = 8'h52;
	localparam logic [7:0] OPC_CHIP_ERASE_A = 8'h60;
	localparam logic [7:0] OPC_SUSPEND_A = 8'h75;
	localparam logic [7:0] OPC_RESUME_A = 8'h7A;
	localparam logic [7:0] OPC_PAGE_ERASE = 8'h81;
	localparam logic [7:0] OPC_DUAL_PROG = 8'hA2;
	localparam logic [7:0] OPC_PD_RELEASE = 8'hAB;
	localparam logic [7:0] OPC_SUSPEND_B = 8'hB0;
	localparam logic [7:0] OPC_PD_ENTER = 8'hB9;
	localparam logic [7:0] OPC_CHIP_ERASE_B = 8'hC7;
	localparam logic [7:0] OPC_BLOCK64_ERASE = 8'hD8;

	// ************************************************************
	// Status word, config byte and read-out copy field positions
	// ************************************************************
	localparam int ST_BUSY = 0;
	localparam int ST_WRITE_LATCH = 1;
	localparam int ST_APC_LO = 2;
	localparam int ST_SPM0 = 7;
	localparam int ST_SPM1 = 8;
	localparam int ST_QPE = 9;
	localparam int ST_PROG_SUS = 10;
	localparam int ST_LOCK_LO = 11;
	localparam int ST_CMP = 14;
	localparam int ST_ERASE_SUS = 15;
	localparam int CF_DUAL_PAGE = 7;
	localparam int MIR_RD_OK = 24;

	// ************************************************************
	// Reset values and protection mode codes of the nonvolatile fields
	// ************************************************************
	localparam logic [4:0] APC_RST = 5'h00;
	localparam logic [1:0] SPM_RST = 2'h0;
	localparam logic [1:0] SPM_POWER_LOCK = 2'h2;
	localparam logic [1:0] SPM_HW_PROT = 2'h1;
	localparam logic [2:0] LOCK_RST = 3'h0;

	// ************************************************************
	// Array and operation sizes in bytes
	// ************************************************************
	localparam logic [20:0] ARRAY_BYTES = 21'h100000;
	localparam logic [20:0] SIZE_256 = 21'h000100;
	localparam logic [20:0] SIZE_512 = 21'h000200;
	localparam logic [20:0] SIZE_4K = 21'h001000;
	localparam logic [20:0] SIZE_32K = 21'h008000;
	localparam logic [20:0] SIZE_64K = 21'h010000;
	localparam logic [20:0] ONE_BYTE = 21'h000001;

	// ************************************************************
	// Byte counts of a command frame
	// ************************************************************
	localparam logic [2:0] NB_OPCODE = 3'h1;
	localparam logic [2:0] NB_REG_WR = 3'h2;
	localparam logic [2:0] NB_REG_WR2 = 3'h3;
	localparam logic [2:0] NB_ADDR_CMD = 3'h4;
	localparam logic [2:0] NB_PROG_MIN = 3'h5;
	localparam logic [2:0] NB_MAX = 3'h7;

	typedef enum logic [1:0] {SFWP_STANDBY, SFWP_BUSY, SFWP_SUSPENDED, SFWP_DEEP_PD} sfwp_state_e;

endpackage : sfwp_pkg

// ### sfwp_sync.sv
// Two-flip-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a level or toggle that stays put for several clocks.
`timescale 1ns/1ps
module sfwp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_sys_rst,
	// Asynchronous levels in, synchronous levels out
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);

	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			meta_r <= RST_VAL;
			sync_r <= RST_VAL;
		end
		else
		begin
			meta_r <= i_async;
			sync_r <= meta_r;
		end
	end

	assign o_sync = sync_r;

endmodule : sfwp_sync

// ### sfwp_write_protect.sv
// Status, configuration and write-protection logic of a serial NOR flash.
// Assumes an SPI host on the link pins and an array datapath fed by the op and buffer outputs.
`timescale 1ns/1ps

// Overview of operation
// - Quad enable 0: spare pins are write-protect and pause; 1: data lines two, three.
// - Three lock bits reset to 0, set singly, never cleared again.
// - Complement bit, default 0, combines with protect code to choose protected region.
// - Suspend (75h/B0h) sets erase or program suspended flag by interrupted operation.
// - Resume (7Ah/30h) or power cycle clears both suspend flags.
// - Dual-page bit defaults 0 for 256-byte page; 1 gives 512-byte page.
// - Dual-page 0 wraps buffer load at 256; 1 uses all 512 bytes.
// - With dual-page 1, page erase 81h erases the whole 512-byte page.
// - Power-up puts the command state machine into standby.
// - Data-changing commands must be whole bytes, ending on a byte boundary.
// - Write-unlock sets the write latch; data changes are refused while it is clear.
// - Protected region stays readable; program and erase there are blocked.
// - Write-protect low in hardware mode locks protect code and mode bits.
// - In deep power-down only the release command is obeyed.
// - Code low bits 000 protect nothing; with top bit 0, 001-100 protect 1/16 to 1/2, end by bit 3.
// - Whole array protected for top bit 0 with 101, or bits 2 and 1 both set.
// - Top bit 1: codes 001,010,011,10x protect 4K to 32K at an end.
// - Complement bit 1 protects exactly the complement of the complement-0 region.
// - Program or erase touching any protected address never starts, though program data still loads the buffer.
// - Write latch clear: no status write, program or erase accepted.
module sfwp_write_protect (
	// System clock and power-up reset
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_nv_init,
	// SPI link
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_data_line_0,
	output logic o_data_line_1,
	output logic o_data_line_1_oe,
	input wire logic i_data_line_2,
	output logic o_data_line_2,
	output logic o_data_line_2_oe,
	input wire logic i_data_line_3,
	output logic o_data_line_3,
	output logic o_data_line_3_oe,
	// Register and pin-function state
	output logic [15:0] o_status_word,
	output logic [7:0] o_config_byte,
	output logic o_quad_data_mode,
	output logic o_write_protect_low,
	output logic o_pause_active,
	output logic [2:0] o_security_lock,
	output logic o_deep_power_down,
	// Array operations
	output logic o_program_go,
	output logic o_erase_go,
	output logic [19:0] o_op_lo,
	output logic [19:0] o_op_hi,
	output logic o_cmd_rejected,
	// Program buffer loading
	output logic o_buf_we,
	output logic [8:0] o_buf_addr,
	output logic [7:0] o_buf_data
);
	import sfwp_pkg::*;

	// ************************************************************
	// Link domain: bit capture and status read-out
	// ************************************************************
	logic [2:0] bit_cnt_r;
	logic [6:0] rx_sh_r;
	logic first_byte_r;
	logic [1:0] rd_sel_r;
	logic [7:0] rx_byte_r;
	logic start_tgl_r;
	logic byte_tgl_r;
	logic [7:0] tx_sh_r;
	logic tx_on_r;
	logic [24:0] rd_mirror_r;
	logic pause_q;

	wire [7:0] rx_full = {rx_sh_r, i_data_line_0};
	wire rd_ok = rd_mirror_r[MIR_RD_OK];
	wire [1:0] rd_sel_nxt = !rd_ok ? 2'h0 :
		(rx_full == OPC_READ_STATUS_LO) ? 2'h1 :
		(rx_full == OPC_READ_STATUS_HI) ? 2'h2 :
		(rx_full == OPC_READ_CONFIG) ? 2'h3 : 2'h0;
	wire [7:0] tx_load = (rd_sel_r == 2'h1) ? rd_mirror_r[7:0] :
		(rd_sel_r == 2'h2) ? rd_mirror_r[15:8] : rd_mirror_r[23:16];

	// Chip select high clears the frame state; the host clock stops outside frames.
	always_ff @(posedge i_sclk or posedge i_cs_n)
	begin
		if (i_cs_n)
		begin
			bit_cnt_r <= 3'h0;
			rx_sh_r <= 7'h00;
			first_byte_r <= 1'b1;
			rd_sel_r <= 2'h0;
		end
		else
		begin
			bit_cnt_r <= bit_cnt_r + 3'h1;
			rx_sh_r <= rx_full[6:0];
			if (bit_cnt_r == 3'h7)
			begin
				first_byte_r <= 1'b0;
				if (first_byte_r)
					rd_sel_r <= rd_sel_nxt;
			end
		end
	end

	// Byte start and end events leave the domain as toggles, so the system side can
	// count whole bytes and spot a frame that stops inside a byte.
	always_ff @(posedge i_sclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			start_tgl_r <= 1'b0;
			byte_tgl_r <= 1'b0;
			rx_byte_r <= 8'h00;
		end
		else if (!i_cs_n)
		begin
			if (bit_cnt_r == 3'h0)
				start_tgl_r <= ~start_tgl_r;
			if (bit_cnt_r == 3'h7)
			begin
				byte_tgl_r <= ~byte_tgl_r;
				rx_byte_r <= rx_full;
			end
		end
	end

	always_ff @(negedge i_sclk or posedge i_cs_n)
	begin
		if (i_cs_n)
		begin
			tx_sh_r <= 8'h00;
			tx_on_r <= 1'b0;
		end
		else if (rd_sel_r != 2'h0 && bit_cnt_r == 3'h0)
		begin
			tx_sh_r <= tx_load;
			tx_on_r <= 1'b1;
		end
		else
			tx_sh_r <= {tx_sh_r[6:0], 1'b0};
	end

	assign o_data_line_1 = tx_sh_r[7];
	assign o_data_line_1_oe = tx_on_r & ~pause_q;
	// The quad datapath lives elsewhere, so the spare lines are only ever inputs here.
	assign o_data_line_2 = 1'b0;
	assign o_data_line_2_oe = 1'b0;
	assign o_data_line_3 = 1'b0;
	assign o_data_line_3_oe = 1'b0;

	// ************************************************************
	// Crossing into the system domain
	// ************************************************************
	logic [4:0] sync_q;
	logic cs_prev_r;
	logic start_prev_r;
	logic byte_prev_r;

	sfwp_sync #(.W(5), .RST_VAL(5'h1C)) u_sync (
		.i_clock(i_clock),
		.i_sys_rst(i_sys_rst),
		.i_async({i_cs_n, i_data_line_2, i_data_line_3, start_tgl_r, byte_tgl_r}),
		.o_sync(sync_q)
	);

	wire cs_q = sync_q[4];
	wire spare2_q = sync_q[3];
	wire spare3_q = sync_q[2];
	wire frame_end = cs_q & ~cs_prev_r;
	wire frame_start = ~cs_q & cs_prev_r;
	wire start_ev = sync_q[1] ^ start_prev_r;
	wire byte_ev = sync_q[0] ^ byte_prev_r;

	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			cs_prev_r <= 1'b1;
			start_prev_r <= 1'b0;
			byte_prev_r <= 1'b0;
		end
		else
		begin
			cs_prev_r <= cs_q;
			start_prev_r <= sync_q[1];
			byte_prev_r <= sync_q[0];
		end
	end

	// ************************************************************
	// Register state
	// ************************************************************
	sfwp_state_e state_r;
	sfwp_state_e state_nxt;
	logic [15:0] op_cnt_r;
	logic op_erase_r;
	logic wel_r;
	logic erase_sus_r;
	logic prog_sus_r;
	logic [4:0] apc_r;
	logic [1:0] spm_r;
	logic qpe_r;
	logic [2:0] lock_r;
	logic cmp_r;
	logic dual_page_r;
	logic [15:0] status_word;

	assign o_quad_data_mode = qpe_r;
	assign o_write_protect_low = ~qpe_r & ~spare2_q;
	assign pause_q = ~qpe_r & ~spare3_q;
	assign o_pause_active = pause_q;
	assign o_security_lock = lock_r;
	assign o_deep_power_down = (state_r == SFWP_DEEP_PD);

	always_comb
	begin
		status_word = 16'h0000;
		status_word[ST_BUSY] = (state_r == SFWP_BUSY);
		status_word[ST_WRITE_LATCH] = wel_r;
		status_word[ST_APC_LO +: 5] = apc_r;
		status_word[ST_SPM0] = spm_r[0];
		status_word[ST_SPM1] = spm_r[1];
		status_word[ST_QPE] = qpe_r;
		status_word[ST_PROG_SUS] = prog_sus_r;
		status_word[ST_LOCK_LO +: 3] = lock_r;
		status_word[ST_CMP] = cmp_r;
		status_word[ST_ERASE_SUS] = erase_sus_r;
	end

	assign o_status_word = status_word;
	assign o_config_byte = {dual_page_r, 7'h00};

	// The read-out copy only moves between frames, so the link side sees a steady word.
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			rd_mirror_r <= 25'h0000000;
		else if (cs_q)
			rd_mirror_r <= {(state_r != SFWP_DEEP_PD), o_config_byte, status_word};
	end

	// ************************************************************
	// Frame assembly
	// ************************************************************
	logic [2:0] nbytes_r;
	logic open_r;
	logic [7:0] opcode_r;
	logic [23:0] addr_r;
	logic [7:0] wd0_r;
	logic [7:0] wd1_r;
	logic [8:0] ld_cnt_r;

	wire is_prog = (opcode_r == OPC_PAGE_PROG) | (opcode_r == OPC_DUAL_PROG) |
		(opcode_r == OPC_QUAD_PROG);
	wire is_chip_erase = (opcode_r == OPC_CHIP_ERASE_A) | (opcode_r == OPC_CHIP_ERASE_B);
	wire is_erase = (opcode_r == OPC_PAGE_ERASE) | (opcode_r == OPC_SECTOR_ERASE) |
		(opcode_r == OPC_BLOCK32_ERASE) | (opcode_r == OPC_BLOCK64_ERASE) | is_chip_erase;
	wire is_wrsr = (opcode_r == OPC_WRITE_STATUS);
	wire is_wrcr = (opcode_r == OPC_WRITE_CONFIG);
	wire is_susp = (opcode_r == OPC_SUSPEND_A) | (opcode_r == OPC_SUSPEND_B);
	wire is_resume = (opcode_r == OPC_RESUME_A) | (opcode_r == OPC_RESUME_B);
	wire is_array = is_prog | is_erase;
	wire buf_load = byte_ev & is_prog & (nbytes_r >= NB_ADDR_CMD) & (state_r != SFWP_DEEP_PD);
	wire [8:0] buf_idx = dual_page_r ? (addr_r[8:0] + ld_cnt_r) :
		{1'b0, addr_r[7:0] + ld_cnt_r[7:0]};

	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst || frame_start)
		begin
			nbytes_r <= 3'h0;
			open_r <= 1'b0;
			opcode_r <= 8'h00;
			ld_cnt_r <= 9'h000;
		end
		else
		begin
			open_r <= start_ev | (open_r & ~byte_ev);
			if (byte_ev && nbytes_r != NB_MAX)
				nbytes_r <= nbytes_r + 3'h1;
			if (byte_ev && nbytes_r == 3'h0)
				opcode_r <= rx_byte_r;
			if (buf_load)
				ld_cnt_r <= ld_cnt_r + 9'h001;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			addr_r <= 24'h000000;
			wd0_r <= 8'h00;
			wd1_r <= 8'h00;
		end
		else if (byte_ev)
		begin
			if (nbytes_r == 3'h1)
			begin
				addr_r[23:16] <= rx_byte_r;
				wd0_r <= rx_byte_r;
			end
			if (nbytes_r == 3'h2)
			begin
				addr_r[15:8] <= rx_byte_r;
				wd1_r <= rx_byte_r;
			end
			if (nbytes_r == 3'h3)
				addr_r[7:0] <= rx_byte_r;
		end
	end

	// ************************************************************
	// Protected region decode
	// ************************************************************
	wire apc_none = (apc_r[2:0] == 3'h0);
	wire apc_all = (~apc_r[4] & (apc_r[2:0] == 3'h5)) | (apc_r[2] & apc_r[1]);
	wire [2:0] sz_exp = (apc_r[4] & apc_r[2]) ? 3'h3 : (apc_r[2:0] - 3'h1);
	wire [20:0] raw_size = (apc_r[4] ? SIZE_4K : SIZE_64K) << sz_exp;
	wire raw_upper = ~apc_r[3];
	wire p_none = cmp_r ? apc_all : apc_none;
	wire p_all = cmp_r ? apc_none : apc_all;
	wire [20:0] p_size = cmp_r ? (ARRAY_BYTES - raw_size) : raw_size;
	wire p_upper = cmp_r ? ~raw_upper : raw_upper;
	wire [20:0] p_lo = (p_all || !p_upper) ? 21'h000000 : (ARRAY_BYTES - p_size);
	wire [20:0] p_hi = (p_all || p_upper) ? (ARRAY_BYTES - ONE_BYTE) : (p_size - ONE_BYTE);

	wire [20:0] page_size = dual_page_r ? SIZE_512 : SIZE_256;
	wire [20:0] op_span = is_chip_erase ? ARRAY_BYTES :
		(opcode_r == OPC_SECTOR_ERASE) ? SIZE_4K :
		(opcode_r == OPC_BLOCK32_ERASE) ? SIZE_32K :
		(opcode_r == OPC_BLOCK64_ERASE) ? SIZE_64K : page_size;
	wire [20:0] op_lo = {1'b0, addr_r[19:0]} & ~(op_span - ONE_BYTE);
	wire [20:0] op_hi = op_lo + op_span - ONE_BYTE;
	// Only program and erase consult the region; reads never look at it.
	wire prot_hit = ~p_none & (op_lo <= p_hi) & (op_hi >= p_lo);

	// ************************************************************
	// Command acceptance
	// ************************************************************
	wire cmd_ok = frame_end & ~open_r & (nbytes_r >= NB_OPCODE);
	wire in_dpd = (state_r == SFWP_DEEP_PD);
	wire standby = (state_r == SFWP_STANDBY);
	wire len_ok = is_prog ? (nbytes_r >= NB_PROG_MIN) :
		is_chip_erase ? 1'b1 :
		is_erase ? (nbytes_r >= NB_ADDR_CMD) : (nbytes_r >= NB_REG_WR);
	wire changes_data = is_array | is_wrsr | is_wrcr;
	wire sr_locked = spm_r[1];
	wire hw_lock = (spm_r == SPM_HW_PROT) & o_write_protect_low;
	wire write_ok = cmd_ok & standby & len_ok & wel_r;
	wire accept_array = write_ok & is_array & ~prot_hit;
	wire accept_wrsr = write_ok & is_wrsr & ~sr_locked;
	wire accept_wrcr = write_ok & is_wrcr;
	wire accepted = accept_array | accept_wrsr | accept_wrcr;
	wire wr_two = (nbytes_r >= NB_REG_WR2);
	wire [15:0] wr_word = {wr_two ? wd1_r : status_word[15:8], wd0_r};
	wire accept_susp = cmd_ok & is_susp & (state_r == SFWP_BUSY);
	wire accept_resume = cmd_ok & is_resume & ~in_dpd;

	// ************************************************************
	// Command state machine
	// ************************************************************
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			SFWP_STANDBY:
			begin
				if (cmd_ok && opcode_r == OPC_PD_ENTER)
					state_nxt = SFWP_DEEP_PD;
				else if (accept_array)
					state_nxt = SFWP_BUSY;
			end
			SFWP_BUSY:
			begin
				if (accept_susp)
					state_nxt = SFWP_SUSPENDED;
				else if (op_cnt_r == 16'h0000)
					state_nxt = SFWP_STANDBY;
			end
			SFWP_SUSPENDED:
			begin
				if (accept_resume)
					state_nxt = SFWP_BUSY;
			end
			SFWP_DEEP_PD:
			begin
				if (frame_end && opcode_r == OPC_PD_RELEASE)
					state_nxt = SFWP_STANDBY;
			end
		endcase
	end

	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			state_r <= SFWP_STANDBY;
		else
			state_r <= state_nxt;
	end

	// The counter holds while suspended so the resumed operation finishes its time.
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			op_cnt_r <= 16'h0000;
			op_erase_r <= 1'b0;
		end
		else if (accept_array)
		begin
			op_cnt_r <= OP_CYCLES - 16'h0001;
			op_erase_r <= is_erase;
		end
		else if (state_r == SFWP_BUSY && op_cnt_r != 16'h0000)
			op_cnt_r <= op_cnt_r - 16'h0001;
	end

	// ************************************************************
	// Volatile flags
	// ************************************************************
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			wel_r <= 1'b0;
			erase_sus_r <= 1'b0;
			prog_sus_r <= 1'b0;
		end
		else
		begin
			if (cmd_ok && !in_dpd && opcode_r == OPC_WRITE_UNLOCK)
				wel_r <= 1'b1;
			else if ((cmd_ok && !in_dpd && opcode_r == OPC_WRITE_LOCK) || accepted)
				wel_r <= 1'b0;
			if (accept_susp)
			begin
				erase_sus_r <= erase_sus_r | op_erase_r;
				prog_sus_r <= prog_sus_r | ~op_erase_r;
			end
			else if (accept_resume)
			begin
				erase_sus_r <= 1'b0;
				prog_sus_r <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Nonvolatile fields
	// ************************************************************
	// A power cycle keeps these, except power-lock mode, which returns to 0; only i_nv_init, held with reset, loads factory defaults.
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			if (i_nv_init)
			begin
				apc_r <= APC_RST;
				spm_r <= SPM_RST;
				qpe_r <= 1'b0;
				lock_r <= LOCK_RST;
				cmp_r <= 1'b0;
				dual_page_r <= 1'b0;
			end
			else if (spm_r == SPM_POWER_LOCK)
				spm_r <= SPM_RST;
		end
		else
		begin
			if (accept_wrsr)
			begin
				if (!hw_lock)
				begin
					apc_r <= wr_word[ST_APC_LO +: 5];
					spm_r <= {wr_word[ST_SPM1], wr_word[ST_SPM0]};
				end
				qpe_r <= wr_word[ST_QPE];
				cmp_r <= wr_word[ST_CMP];
				lock_r <= lock_r | wr_word[ST_LOCK_LO +: 3];
			end
			if (accept_wrcr)
				dual_page_r <= wd0_r[CF_DUAL_PAGE];
		end
	end

	// ************************************************************
	// Array operation and buffer outputs
	// ************************************************************
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			o_program_go <= 1'b0;
			o_erase_go <= 1'b0;
			o_op_lo <= 20'h00000;
			o_op_hi <= 20'h00000;
			o_cmd_rejected <= 1'b0;
			o_buf_we <= 1'b0;
			o_buf_addr <= 9'h000;
			o_buf_data <= 8'h00;
		end
		else
		begin
			o_program_go <= accept_array & is_prog;
			o_erase_go <= accept_array & is_erase;
			if (accept_array)
			begin
				o_op_lo <= op_lo[19:0];
				o_op_hi <= op_hi[19:0];
			end
			// Deep power-down ignores commands outright, so it reports no refusal either.
			o_cmd_rejected <= frame_end & changes_data & ~accepted & ~in_dpd;
			o_buf_we <= buf_load;
			if (buf_load)
			begin
				o_buf_addr <= buf_idx;
				o_buf_data <= rx_byte_r;
			end
		end
	end

endmodule : sfwp_write_protect

// ### sfwp_monitor.sv
// Port checker of the write-protect block.
// Assumes it is bound to sfwp_write_protect and sees only its ports.
`timescale 1ns/1ps
module sfwp_monitor (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_sys_rst,
	// Observed outputs
	input wire logic [15:0] o_status_word,
	input wire logic [7:0] o_config_byte,
	input wire logic o_quad_data_mode,
	input wire logic o_write_protect_low,
	input wire logic o_pause_active,
	input wire logic [2:0] o_security_lock,
	input wire logic o_deep_power_down,
	input wire logic o_program_go,
	input wire logic o_erase_go,
	input wire logic o_cmd_rejected,
	input wire logic o_buf_we,
	input wire logic [8:0] o_buf_addr
);
	import sfwp_pkg::*;
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	sequence go_s;
		o_program_go || o_erase_go;
	endsequence
	latch_need_a: assert property (go_s |-> $past(o_status_word[ST_WRITE_LATCH]))
		else $error("operation started without write latch");
	go_busy_a: assert property (go_s |=> !o_program_go && !o_erase_go ##[0:2] o_status_word[0])
		else $error("operation start is not one pulse followed by busy");
	lock_keep_a: assert property ((o_security_lock & $past(o_security_lock)) == $past(o_security_lock))
		else $error("security lock bit returned to zero");
	pd_quiet_a: assert property (o_deep_power_down |-> !o_program_go && !o_erase_go && !o_cmd_rejected)
		else $error("command obeyed in deep power-down");
	quad_pins_a: assert property (o_quad_data_mode |-> !o_write_protect_low && !o_pause_active)
		else $error("pin function active in quad mode");
	sus_cause_a: assert property ($rose(o_status_word[ST_ERASE_SUS]) || $rose(o_status_word[ST_PROG_SUS])
		|-> $past(o_status_word[ST_BUSY]) && !o_status_word[ST_BUSY])
		else $error("suspend flag set without interrupted operation");
	wrap_low_a: assert property (o_buf_we && !o_config_byte[CF_DUAL_PAGE] |-> !o_buf_addr[8])
		else $error("buffer address passed 256 with single page");
	power_up_a: assert property ($fell(i_sys_rst) |-> o_status_word[1:0] == 2'h0 && !o_deep_power_down
		&& !o_status_word[ST_ERASE_SUS] && !o_status_word[ST_PROG_SUS])
		else $error("state not standby after power-up");
endmodule : sfwp_monitor
bind sfwp_write_protect sfwp_monitor u_mon (.i_clock, .i_sys_rst, .o_status_word, .o_config_byte,
	.o_quad_data_mode, .o_write_protect_low, .o_pause_active, .o_security_lock,
	.o_deep_power_down, .o_program_go, .o_erase_go, .o_cmd_rejected, .o_buf_we, .o_buf_addr);

// ### sfwp_host.sv
// SPI host model sending mode 0 frames, MSB first.
// Assumes the device samples data on the rising link clock edge.
`timescale 1ns/1ps
module sfwp_host (
	// Link pins
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_mosi
);
	initial
	begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_mosi = 1'b0;
	end
	// A bit count that is not a whole byte makes a broken frame on purpose.
	task frame(input logic [55:0] d, input int nbit);
		#37 o_cs_n = 1'b0;
		for (int i = 0; i < nbit; i++)
		begin
			o_mosi = d[55 - i];
			#80 o_sclk = 1'b1;
			#80 o_sclk = 1'b0;
		end
		#40 o_cs_n = 1'b1;
		o_mosi = ~o_mosi;
		#200;
	endtask : frame
endmodule : sfwp_host

// ### tb_top.sv
// Self-checking bench of the write-protect block.
// Assumes an 8 ns system clock and a 160 ns link clock within frames.
`timescale 1ns/1ps
module tb_top;
	import sfwp_pkg::*;
	logic i_clock = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_nv_init = 1'b1;
	logic sclk, cs_n, mosi, dpd, pgo, ego, rej, bwe, wpl, pau;
	logic [7:0] cfg;
	logic wp_n = 1'b1;
	logic [15:0] st;
	logic [19:0] lo, hi;
	logic [8:0] ba;
	int n_mismatch = 0;
	int n_compared = 0;
	int n_pg = 0, n_er = 0, n_rj = 0, n_we = 0;
	always #4 i_clock = ~i_clock;
	sfwp_host u_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi));
	sfwp_write_protect u_dut (.i_clock, .i_sys_rst, .i_nv_init, .i_sclk(sclk), .i_cs_n(cs_n),
		.i_data_line_0(mosi), .o_data_line_1(), .o_data_line_1_oe(), .i_data_line_2(wp_n),
		.o_data_line_2(), .o_data_line_2_oe(), .i_data_line_3(wp_n), .o_data_line_3(),
		.o_data_line_3_oe(), .o_status_word(st), .o_config_byte(cfg), .o_quad_data_mode(),
		.o_write_protect_low(wpl), .o_pause_active(pau), .o_security_lock(),
		.o_deep_power_down(dpd), .o_program_go(pgo), .o_erase_go(ego), .o_op_lo(lo),
		.o_op_hi(hi), .o_cmd_rejected(rej), .o_buf_we(bwe), .o_buf_addr(ba), .o_buf_data());
	always @(posedge i_clock)
	begin
		n_pg <= n_pg + int'(pgo === 1'b1);
		n_er <= n_er + int'(ego === 1'b1);
		n_rj <= n_rj + int'(rej === 1'b1);
		n_we <= n_we + int'(bwe === 1'b1);
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk
	task test_done;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	task snd(input logic [7:0] op, input logic [47:0] rest, input int nb);
		u_host.frame({op, rest}, nb);
		@(negedge i_clock);
	endtask : snd
	task idle;
		int k;
		for (k = 0; k < 400 && st[ST_BUSY] !== 1'b0; k++)
			@(negedge i_clock);
		if (k == 400)
		begin
			n_mismatch++;
			test_done();
		end
	endtask : idle
	task t_latch;
		snd(OPC_WRITE_UNLOCK, '0, 12);
		chk("latch", st[ST_WRITE_LATCH], 0);
		snd(OPC_SECTOR_ERASE, 48'h001000_000000, 32);
		chk("rejected", n_rj, 1);
		snd(OPC_WRITE_UNLOCK, '0, 8);
		chk("latch", st[ST_WRITE_LATCH], 1);
		snd(OPC_PAGE_PROG, 48'h0001FE_A55A3C, 56);
		chk("buf writes", n_we, 3);
		chk("buf addr", ba, 0);
		chk("prog go", n_pg, 1);
		chk("page lo", lo, 20'h00100);
		chk("page hi", hi, 20'h001FF);
		idle();
		chk("latch", st[ST_WRITE_LATCH], 0);
		$display("t_latch done");
	endtask : t_latch
	task t_prot;
		snd(OPC_WRITE_UNLOCK, '0, 8);
		snd(OPC_WRITE_STATUS, 48'h04_0000000000, 16);
		chk("protect code", st[6:2], 1);
		snd(OPC_WRITE_UNLOCK, '0, 8);
		snd(OPC_SECTOR_ERASE, 48'h0FF000_000000, 32);
		chk("rejected", n_rj, 2);
		for (int i = 0; i < 2; i++)
		begin
			snd(OPC_WRITE_UNLOCK, '0, 8);
			snd(OPC_SECTOR_ERASE, '0, 32);
			chk("erase go", n_er, i + 1);
			snd(i ? OPC_SUSPEND_B : OPC_SUSPEND_A, '0, 8);
			chk("erase sus", st[ST_ERASE_SUS], 1);
			chk("busy", st[ST_BUSY], 0);
			snd(i ? OPC_RESUME_B : OPC_RESUME_A, '0, 8);
			chk("erase sus", st[ST_ERASE_SUS], 0);
			idle();
		end
		$display("t_prot done");
	endtask : t_prot
	task t_pd;
		snd(OPC_PD_ENTER, '0, 8);
		chk("deep pd", dpd, 1);
		snd(OPC_WRITE_UNLOCK, '0, 8);
		chk("latch", st[ST_WRITE_LATCH], 0);
		snd(OPC_SECTOR_ERASE, '0, 32);
		chk("rejected", n_rj, 2);
		snd(OPC_PD_RELEASE, '0, 8);
		chk("deep pd", dpd, 0);
		$display("t_pd done");
	endtask : t_pd
	task t_dual;
		snd(OPC_WRITE_UNLOCK, '0, 8);
		snd(OPC_WRITE_CONFIG, 48'h80_0000000000, 16);
		chk("config", cfg, 8'h80);
		snd(OPC_WRITE_UNLOCK, '0, 8);
		snd(OPC_PAGE_ERASE, 48'h000300_000000, 32);
		chk("erase go", n_er, 3);
		chk("page lo", lo, 20'h00200);
		chk("page hi", hi, 20'h003FF);
		idle();
		snd(OPC_WRITE_UNLOCK, '0, 8);
		snd(OPC_PAGE_PROG, 48'h0000FF_A55A00, 48);
		chk("buf addr", ba, 9'h100);
		chk("buf writes", n_we, 5);
		chk("page hi", hi, 20'h001FF);
		snd(OPC_SUSPEND_A, '0, 8);
		chk("prog sus", st[ST_PROG_SUS], 1);
		snd(OPC_RESUME_A, '0, 8);
		idle();
		$display("t_dual done");
	endtask : t_dual
	task t_hw;
		wp_n = 1'b0;
		snd(OPC_WRITE_UNLOCK, '0, 8);
		chk("pin fn", {wpl, pau}, 2'h3);
		snd(OPC_WRITE_STATUS, 48'h80_0000000000, 16);
		snd(OPC_WRITE_UNLOCK, '0, 8);
		snd(OPC_WRITE_STATUS, 48'h840A_00000000, 24);
		chk("status", st, 16'h0A80);
		chk("pin fn", {wpl, pau}, 2'h0);
		$display("t_hw done");
	endtask : t_hw
	initial
	begin
		repeat (4) @(negedge i_clock);
		i_sys_rst = 1'b0;
		i_nv_init = 1'b0;
		repeat (3) @(negedge i_clock);
		chk("status", st, 0);
		chk("deep pd", dpd, 0);
		t_latch();
		t_prot();
		t_pd();
		t_dual();
		t_hw();
		test_done();
	end
endmodule : tb_top
